// file: src/mfx_defines.vh
`ifndef MFX_DEFINES_VH
`define MFX_DEFINES_VH

// Status flag bit positions
`define MFX_FLAG_AZ_BIT      0
`define MFX_FLAG_AN_BIT      1
`define MFX_FLAG_AV_BIT      2
`define MFX_FLAG_AC_BIT      3
`define MFX_FLAG_AS_BIT      4
`define MFX_FLAG_AQ_BIT      5
`define MFX_FLAG_MV_BIT      6
`define MFX_FLAG_SS_BIT      7
`define MFX_FLAGS_RESET      8'h00

// Register-port offsets
`define MFX_REG_FLAGS        4'h0
`define MFX_REG_INSN         4'h1
`define MFX_REG_IRQ_STATUS   4'h2
`define MFX_REG_IRQ_MASK     4'h3
`define MFX_REG_REGSEL       4'h4
`define MFX_REG_REGDATA      4'h5
`define MFX_REG_IDXSEL       4'h6
`define MFX_REG_IDXDATA      4'h7
`define MFX_REG_MODDATA      4'h8

// Instruction prefixes
`define MFX_PFX_T8           5'h05
`define MFX_PFX_T14          9'h020
`define MFX_PFX_T4           3'h3
`define MFX_BIT_T4           1'h1
`define MFX_PFX_T5           5'h0b

// Decoded kinds
`define MFX_KIND_NONE        3'h0
`define MFX_KIND_T8          3'h1
`define MFX_KIND_T14         3'h2
`define MFX_KIND_T4          3'h3
`define MFX_KIND_T5          3'h4

// Shifter function code for exponent detect
`define MFX_SF_EXP           4'hc

// Interrupt event bits
`define MFX_IRQ_DONE_BIT     0
`define MFX_IRQ_ILLEGAL_BIT  1
`define MFX_IRQ_MACOV_BIT    2

`endif

// file: src/mfx_decode.v
`timescale 1ns/1ps
`include "mfx_defines.vh"

module mfx_decode (
	input  wire [23:0] insn,
	output reg  [2:0]  kind,
	output wire        result_sel,
	output wire [4:0]  alu_mac_function_field,
	output wire [3:0]  sf,
	output wire [1:0]  yop,
	output wire [2:0]  xop,
	output wire [3:0]  dst_sel,
	output wire [3:0]  src_sel,
	output wire        dag_sel,
	output wire [1:0]  idx_sel,
	output wire [1:0]  mod_sel
);
	assign result_sel = insn[18];
	assign alu_mac_function_field        = insn[17:13];
	assign yop        = insn[12:11];
	assign xop        = insn[10:8];
	assign sf         = insn[14:11];
	assign dst_sel    = insn[7:4];
	assign src_sel    = insn[3:0];
	assign dag_sel    = insn[20];
	assign idx_sel    = insn[3:2];
	assign mod_sel    = insn[1:0];

	always @* begin
		if (insn[23:19] == `MFX_PFX_T8)
			kind = `MFX_KIND_T8;
		else if (insn[23:15] == `MFX_PFX_T14)
			kind = `MFX_KIND_T14;
		else if (insn[23:21] == `MFX_PFX_T4 && insn[19] == `MFX_BIT_T4)
			kind = `MFX_KIND_T4;
		else if (insn[23:19] == `MFX_PFX_T5)
			kind = `MFX_KIND_T5;
		else
			kind = `MFX_KIND_NONE;
	end
endmodule

// file: src/mfx_compute.v
`timescale 1ns/1ps
`include "mfx_defines.vh"

// Simplified compute: ALU add/sub/abs, MAC accumulate, shifter exp/pass.
module mfx_compute (
	input  wire        is_shift,
	input  wire [4:0]  alu_mac_function_field,
	input  wire [3:0]  sf,
	input  wire [15:0] x_val,
	input  wire [15:0] y_val,
	input  wire [39:0] mac_acc,
	input  wire [7:0]  flags_in,
	output reg  [15:0] alu_res,
	output reg  [39:0] mac_res,
	output reg  [15:0] shf_res,
	output reg         is_mac,
	output reg  [7:0]  flags_out
);
	reg [16:0] sum;
	reg [31:0] prod;
	reg        ovf;
	always @* begin
		sum       = 17'h00000;
		prod      = 32'h00000000;
		ovf       = 1'b0;
		alu_res   = 16'h0000;
		mac_res   = mac_acc;
		shf_res   = x_val;
		is_mac    = 1'b0;
		flags_out = flags_in;
		if (is_shift) begin
			if (sf == `MFX_SF_EXP) begin
				shf_res = 16'h0000;
				flags_out[`MFX_FLAG_SS_BIT] = x_val[15];
			end
		end else if (alu_mac_function_field[4]) begin
			// MAC: accumulate signed product
			is_mac  = 1'b1;
			prod    = $signed(x_val) * $signed(y_val);
			mac_res = mac_acc + {{8{prod[31]}}, prod};
			// Overflow when guard bits differ from bit 31
			ovf = ~((mac_res[39:31] == 9'h000) || (mac_res[39:31] == 9'h1ff));
			flags_out[`MFX_FLAG_MV_BIT] = ovf;
		end else begin
			case (alu_mac_function_field[3:0])
				4'h1:    sum = {1'b0, x_val} + {1'b0, ~y_val} + 17'h00001;
				4'h2:    sum = x_val[15] ? ({1'b0, ~x_val} + 17'h00001) : {1'b0, x_val};
				default: sum = {1'b0, x_val} + {1'b0, y_val};
			endcase
			alu_res = sum[15:0];
			flags_out[`MFX_FLAG_AZ_BIT] = (sum[15:0] == 16'h0000);
			flags_out[`MFX_FLAG_AN_BIT] = sum[15];
			flags_out[`MFX_FLAG_AC_BIT] = sum[16];
			flags_out[`MFX_FLAG_AV_BIT] = (alu_mac_function_field[3:0] == 4'h1)
				? ((x_val[15] != y_val[15]) && (sum[15] != x_val[15]))
				: ((x_val[15] == y_val[15]) && (sum[15] != x_val[15]));
			if (alu_mac_function_field[3:0] == 4'h2)
				flags_out[`MFX_FLAG_AS_BIT] = x_val[15];
		end
	end
endmodule

// file: src/mfx_core.v
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "mfx_defines.vh"

module mfx_core (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	output reg         irq,
	output reg         dm_wr,
	output reg  [13:0] dm_addr,
	output reg  [23:0] dm_wdata,
	output reg         pm_wr,
	output reg  [13:0] pm_addr,
	output reg  [23:0] pm_wdata
);
	// Register file indices: 0..3 ax0,ax1,ay0,ay1; 4 ar; 5..8 mx0,mx1,my0,my1;
	// 9..11 mr0,mr1,mr2; 12 si; 13 se; 14 sr0; 15 sr1
	reg  [15:0] rf [0:15];
	reg  [13:0] idx_reg [0:7];
	reg  [13:0] mod_reg [0:7];
	reg  [7:0]  arith_status_flags;
	reg  [2:0]  irq_status;
	reg  [2:0]  irq_mask;
	reg  [3:0]  regsel;
	reg  [2:0]  idxsel;
	reg  [23:0] insn;
	reg         issue;

	wire [2:0]  kind;
	wire        result_sel;
	wire [4:0]  alu_mac_function_field;
	wire [3:0]  sf;
	wire [1:0]  yop;
	wire [2:0]  xop;
	wire [3:0]  dst_sel;
	wire [3:0]  src_sel;
	wire        dag_sel;
	wire [1:0]  idx_sel;
	wire [1:0]  mod_sel;

	mfx_decode u_dec (
		.insn       (insn),
		.kind       (kind),
		.result_sel (result_sel),
		.alu_mac_function_field        (alu_mac_function_field),
		.sf         (sf),
		.yop        (yop),
		.xop        (xop),
		.dst_sel    (dst_sel),
		.src_sel    (src_sel),
		.dag_sel    (dag_sel),
		.idx_sel    (idx_sel),
		.mod_sel    (mod_sel)
	);

	// Operand selection from start-of-cycle register values
	function [3:0] xop_index;
		input       mac;
		input [2:0] code;
		begin
			case (code)
				3'h0:    xop_index = mac ? 4'h5 : 4'h0;
				3'h1:    xop_index = mac ? 4'h6 : 4'h1;
				3'h2:    xop_index = 4'h4;
				3'h3:    xop_index = 4'h9;
				3'h4:    xop_index = 4'ha;
				3'h5:    xop_index = 4'hb;
				3'h6:    xop_index = 4'he;
				default: xop_index = 4'hf;
			endcase
		end
	endfunction

	wire        is_shift = (kind == `MFX_KIND_T14);
	wire        is_mem   = (kind == `MFX_KIND_T4) || (kind == `MFX_KIND_T5);
	wire        valid    = (kind != `MFX_KIND_NONE);
	wire [15:0] x_val    = rf[xop_index(alu_mac_function_field[4], xop)];
	// MAC Y operands are my0/my1 at 7/8; ALU Y operands are ay0/ay1 at 2/3
	wire [15:0] y_val    = rf[alu_mac_function_field[4] ? (yop[0] ? 4'h8 : 4'h7) : {3'h1, yop[0]}];
	wire [39:0] mac_acc  = {rf[11][7:0], rf[10], rf[9]};
	wire [15:0] src_val  = rf[src_sel];
	wire [15:0] mem_src  = rf[dst_sel];
	// Data writes pick DAG bank by G; program writes use second bank only
	wire [2:0]  ibank    = {(kind == `MFX_KIND_T5) | dag_sel, idx_sel};
	wire [2:0]  mbank    = {(kind == `MFX_KIND_T5) | dag_sel, mod_sel};

	wire [15:0] alu_res;
	wire [39:0] mac_res;
	wire [15:0] shf_res;
	wire        is_mac;
	wire [7:0]  next_flags;

	mfx_compute u_cmp (
		.is_shift  (is_shift),
		.alu_mac_function_field       (alu_mac_function_field),
		.sf        (sf),
		.x_val     (x_val),
		.y_val     (y_val),
		.mac_acc   (mac_acc),
		.flags_in  (arith_status_flags),
		.alu_res   (alu_res),
		.mac_res   (mac_res),
		.shf_res   (shf_res),
		.is_mac    (is_mac),
		.flags_out (next_flags)
	);

	wire        mac_ov    = is_mac && next_flags[`MFX_FLAG_MV_BIT];
	wire [2:0]  irq_event = {issue & valid & mac_ov, issue & ~valid, issue & valid};
	wire        sw_flags  = reg_wr && (reg_addr == `MFX_REG_FLAGS);
	wire        sw_reg    = reg_wr && (reg_addr == `MFX_REG_REGDATA);
	wire        sw_idx    = reg_wr && (reg_addr == `MFX_REG_IDXDATA);
	wire        sw_mod    = reg_wr && (reg_addr == `MFX_REG_MODDATA);

	integer i;
	// All writes land on the clock edge that ends the instruction cycle
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < 16; i = i + 1)
				rf[i] <= 16'h0000;
			for (i = 0; i < 8; i = i + 1) begin
				idx_reg[i] <= 14'h0000;
				mod_reg[i] <= 14'h0000;
			end
			arith_status_flags <= `MFX_FLAGS_RESET;
			insn               <= 24'h000000;
			issue              <= 1'b0;
			regsel             <= 4'h0;
			idxsel             <= 3'h0;
		end else begin
			issue <= reg_wr && (reg_addr == `MFX_REG_INSN);
			if (reg_wr && reg_addr == `MFX_REG_INSN)
				insn <= reg_wdata[23:0];
			if (reg_wr && reg_addr == `MFX_REG_REGSEL)
				regsel <= reg_wdata[3:0];
			if (reg_wr && reg_addr == `MFX_REG_IDXSEL)
				idxsel <= reg_wdata[2:0];
			if (sw_reg)
				rf[regsel] <= reg_wdata[15:0];
			if (sw_idx)
				idx_reg[idxsel] <= reg_wdata[13:0];
			if (sw_mod)
				mod_reg[idxsel] <= reg_wdata[13:0];
			if (sw_flags)
				arith_status_flags <= reg_wdata[7:0];
			if (issue && valid) begin
				arith_status_flags <= next_flags;
				// Computation result; ordered before the move so the move wins only on illegal overlap
				if (is_shift)
					rf[14] <= shf_res;
				else if (is_mac) begin
					rf[9]  <= mac_res[15:0];
					rf[10] <= mac_res[31:16];
					rf[11] <= {{8{mac_res[39]}}, mac_res[39:32]};
				end else
					rf[4] <= alu_res;
				if (!is_mem)
					rf[dst_sel] <= src_val;
				else
					idx_reg[ibank] <= idx_reg[ibank] + mod_reg[mbank];
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dm_wr    <= 1'b0;
			dm_addr  <= 14'h0000;
			dm_wdata <= 24'h000000;
			pm_wr    <= 1'b0;
			pm_addr  <= 14'h0000;
			pm_wdata <= 24'h000000;
		end else begin
			dm_wr <= issue && (kind == `MFX_KIND_T4);
			pm_wr <= issue && (kind == `MFX_KIND_T5);
			// Each space keeps its last address and data while the other is written
			if (issue && kind == `MFX_KIND_T4) begin
				dm_addr  <= idx_reg[ibank];
				// Source right-justified; upper bits zero
				dm_wdata <= {8'h00, mem_src};
			end
			if (issue && kind == `MFX_KIND_T5) begin
				pm_addr  <= idx_reg[ibank];
				pm_wdata <= {8'h00, mem_src};
			end
		end
	end

	// Sticky events, write one to clear; a new event wins over its clear
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= 3'h0;
			irq_mask   <= 3'h0;
			irq        <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `MFX_REG_IRQ_MASK)
				irq_mask <= reg_wdata[2:0];
			if (reg_wr && reg_addr == `MFX_REG_IRQ_STATUS)
				irq_status <= (irq_status & ~reg_wdata[2:0]) | irq_event;
			else
				irq_status <= irq_status | irq_event;
			irq <= |(irq_status & irq_mask);
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			case (reg_addr)
				`MFX_REG_FLAGS:      reg_rdata <= {24'h000000, arith_status_flags};
				`MFX_REG_INSN:       reg_rdata <= {8'h00, insn};
				`MFX_REG_IRQ_STATUS: reg_rdata <= {29'h00000000, irq_status};
				`MFX_REG_IRQ_MASK:   reg_rdata <= {29'h00000000, irq_mask};
				`MFX_REG_REGSEL:     reg_rdata <= {28'h0000000, regsel};
				`MFX_REG_REGDATA:    reg_rdata <= {16'h0000, rf[regsel]};
				`MFX_REG_IDXSEL:     reg_rdata <= {29'h00000000, idxsel};
				`MFX_REG_IDXDATA:    reg_rdata <= {18'h00000, idx_reg[idxsel]};
				`MFX_REG_MODDATA:    reg_rdata <= {18'h00000, mod_reg[idxsel]};
				default:             reg_rdata <= 32'h00000000;
			endcase
		end else
			reg_rdata <= 32'h00000000;
	end
endmodule

// file: bench/mfx_core_props.sv
`timescale 1ns/1ps
`include "mfx_defines.vh"
module mfx_core_props (
	input wire        clk_sys,
	input wire        rst_n,
	input wire [3:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire        irq,
	input wire        dm_wr,
	input wire [13:0] dm_addr,
	input wire [23:0] dm_wdata,
	input wire        pm_wr,
	input wire [13:0] pm_addr,
	input wire [23:0] pm_wdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire iw  = reg_wr && reg_addr == `MFX_REG_INSN;
	wire t4  = iw && reg_wdata[23:21] == `MFX_PFX_T4 && reg_wdata[19] == `MFX_BIT_T4;
	wire t5  = iw && reg_wdata[23:19] == `MFX_PFX_T5;
	wire t8  = iw && reg_wdata[23:19] == `MFX_PFX_T8;
	wire t14 = iw && reg_wdata[23:15] == `MFX_PFX_T14;
	property p_t4; t4 |-> ##2 dm_wr && !pm_wr; endproperty
	property p_t5; t5 |-> ##2 pm_wr && !dm_wr; endproperty
	property p_t8; t8 |-> ##2 !dm_wr && !pm_wr; endproperty
	property p_t14; t14 |-> ##2 !(dm_wr || pm_wr); endproperty
	property p_dm_cause; dm_wr |-> $past(t4, 2); endproperty
	property p_pm_cause; pm_wr |-> $past(t5, 2); endproperty
	property p_dm_data; dm_wr |-> dm_wdata[23:16] == 8'h00; endproperty
	// Address must hold between strobes for slow memories
	property p_dm_hold; !dm_wr |-> $stable(dm_addr); endproperty
	a_t4: assert property (p_t4) else $error("data write missing");
	a_t5: assert property (p_t5) else $error("program write missing");
	a_t8: assert property (p_t8) else $error("move form wrote memory");
	a_t14: assert property (p_t14) else $error("shift move form wrote memory");
	a_dm_cause: assert property (p_dm_cause) else $error("data write without cause");
	a_pm_cause: assert property (p_pm_cause) else $error("program write without cause");
	a_dm_data: assert property (p_dm_data) else $error("data word not right aligned");
	a_dm_hold: assert property (p_dm_hold) else $error("data address moved");
	c_dm: cover property (dm_wr);
	c_pm: cover property (pm_wr);
	c_irq: cover property ($rose(irq));
endmodule

bind mfx_core mfx_core_props mfx_core_props_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
	.dm_wr(dm_wr), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
	.pm_wr(pm_wr), .pm_addr(pm_addr), .pm_wdata(pm_wdata)
);

// file: bench/mfx_mem_model.sv
`timescale 1ns/1ps
module mfx_mem_model (
	input wire        clk_sys,
	input wire        dm_wr,
	input wire [13:0] dm_addr,
	input wire [23:0] dm_wdata,
	input wire        pm_wr,
	input wire [13:0] pm_addr,
	input wire [23:0] pm_wdata
);
	reg [23:0] dm [0:16383];
	reg [23:0] pm [0:16383];
	// Writes land at the end of the strobe cycle
	always @(posedge clk_sys) begin
		if (dm_wr) dm[dm_addr] <= dm_wdata;
		if (pm_wr) pm[pm_addr] <= pm_wdata;
	end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
`include "mfx_defines.vh"
module tb;
	reg         clk_sys;
	reg         rst_n;
	reg  [3:0]  reg_addr;
	reg  [31:0] reg_wdata;
	reg         reg_wr;
	reg         reg_rd;
	wire [31:0] reg_rdata;
	wire        irq;
	wire        dm_wr;
	wire [13:0] dm_addr;
	wire [23:0] dm_wdata;
	wire        pm_wr;
	wire [13:0] pm_addr;
	wire [23:0] pm_wdata;
	integer     n_fail;
	integer     n_compared;
	integer     cyc;
	reg  [31:0] rv;
	mfx_core mfx_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .dm_wr(dm_wr), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .pm_wr(pm_wr), .pm_addr(pm_addr), .pm_wdata(pm_wdata));
	mfx_mem_model mfx_mem_model_inst (.clk_sys(clk_sys), .dm_wr(dm_wr), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
		.pm_wr(pm_wr), .pm_addr(pm_addr), .pm_wdata(pm_wdata));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task end_sim;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 8000) begin
			n_fail = n_fail + 1;
			end_sim;
		end
	end
	task chk(input string nm, input [31:0] e, input [31:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd(input [3:0] a);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// Equal contents everywhere keeps results independent of operand select mapping
	task set_all(input [15:0] v);
		integer i;
		for (i = 0; i < 16; i = i + 1) begin
			wr(`MFX_REG_REGSEL, i);
			wr(`MFX_REG_REGDATA, {16'h0, v});
		end
	endtask
	task rf(input [3:0] i, input [31:0] e, input string nm);
		wr(`MFX_REG_REGSEL, {28'h0, i});
		rd(`MFX_REG_REGDATA);
		chk(nm, e, rv);
	endtask
	task exec(input [23:0] w);
		wr(`MFX_REG_INSN, {8'h0, w});
		@(posedge clk_sys);
		#1;
	endtask
	task run_flag(input [15:0] v, input [23:0] w, input [31:0] pre, input [31:0] e);
		set_all(v);
		wr(`MFX_REG_FLAGS, pre);
		exec(w);
		rd(`MFX_REG_FLAGS);
		chk("flags", e, rv);
	endtask
	task t_reset;
		rd(`MFX_REG_FLAGS);
		chk("flags", 32'h0, rv);
		rd(4'hf);
		chk("unmapped", 32'h0, rv);
		wr(4'hf, 32'hffff_ffff);
		wr(`MFX_REG_FLAGS, 32'hff);
		rd(`MFX_REG_FLAGS);
		chk("flags", 32'hff, rv);
	endtask
	task t_alu_move;
		set_all(16'hc000);
		wr(`MFX_REG_FLAGS, 32'he0);
		exec(24'h286004);
		rf(4'h4, 32'h8000, "ar");
		rf(4'h0, 32'hc000, "ax0");
		rd(`MFX_REG_FLAGS);
		chk("flags", 32'hea, rv);
	endtask
	task t_mac;
		run_flag(16'h0000, 24'h2a0011, 32'he0, 32'ha0);
		wr(`MFX_REG_IRQ_STATUS, 32'h7);
		run_flag(16'h4040, 24'h2a0011, 32'h00, 32'h40);
		rd(`MFX_REG_IRQ_STATUS);
		chk("status", 32'h5, rv);
	endtask
	task t_shift;
		run_flag(16'hc000, 24'h106011, 32'h60, 32'he0);
		run_flag(16'h0003, 24'h106011, 32'he0, 32'h60);
		run_flag(16'hc000, 24'h100011, 32'h5f, 32'h5f);
	endtask
	task mem_case(input [23:0] w, input [2:0] ii, input [2:0] mi, input [13:0] iv, input [13:0] mv, input pmsel);
		reg [13:0] s;
		s = iv + mv;
		set_all(16'h0123);
		wr(`MFX_REG_IDXSEL, {29'h0, mi});
		wr(`MFX_REG_MODDATA, {18'h0, mv});
		wr(`MFX_REG_IDXSEL, {29'h0, ii});
		wr(`MFX_REG_IDXDATA, {18'h0, iv});
		exec(w);
		chk("strobe", 32'h1, {31'h0, pmsel ? pm_wr : dm_wr});
		@(posedge clk_sys);
		#1 chk("memory", 32'h123, {8'h0, pmsel ? mfx_mem_model_inst.pm[iv] : mfx_mem_model_inst.dm[iv]});
		rd(`MFX_REG_IDXDATA);
		chk("index", {18'h0, s}, rv);
		rf(4'h4, 32'h246, "ar");
	endtask
	task t_mem;
		mem_case(24'h78604b, 3'h6, 3'h7, 14'h0100, 14'h0005, 1'b0);
		mem_case(24'h686046, 3'h1, 3'h2, 14'h0200, 14'h3fff, 1'b0);
		mem_case(24'h586044, 3'h5, 3'h4, 14'h3fff, 14'h0001, 1'b1);
	endtask
	task t_irq;
		wr(`MFX_REG_IRQ_MASK, 32'h0);
		wr(`MFX_REG_IRQ_STATUS, 32'h7);
		exec(24'h000000);
		rd(`MFX_REG_IRQ_STATUS);
		chk("unrecognised", 32'h2, rv & 32'h2);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`MFX_REG_IRQ_MASK, 32'h2);
		@(posedge clk_sys);
		#1 chk("irq", 32'h1, {31'h0, irq});
		wr(`MFX_REG_IRQ_STATUS, 32'h2);
		@(posedge clk_sys);
		#1 chk("irq", 32'h0, {31'h0, irq});
	endtask
	initial begin
		n_fail = 0;
		n_compared = 0;
		cyc = 0;
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset;
		t_alu_move;
		t_mac;
		t_shift;
		t_mem;
		t_irq;
		end_sim;
	end
endmodule
